// ===== src/srhp_port.sv
`timescale 1ns/10ps
`include "srhp_regs.svh"

// Function
// RULE_01 - Status byte leads every SPI reply; bits 7, 5, 3 read zero.
// RULE_02 - Status bit 6 set while any motion stop condition is active.
// RULE_03 - Status bit 4 follows ramp status bit 9, position reached.
// RULE_04 - Status bit 2 follows ramp status bit 8, velocity reached.
// RULE_05 - Status bit 1 follows driver error flag, cleared by writing one.
// RULE_06 - Status bit 0 follows reset flag, cleared by writing one.
// RULE_07 - Register data right aligned in the 32-bit word.
// RULE_08 - Frame data shifts only while chip select is low.
// RULE_09 - Sample input on rising clock, change output after falling, MSB first.
// RULE_10 - Host uses SPI mode 3, clock idles high.
// RULE_11 - Host gives at least 40 clocks per transaction.
// RULE_12 - Extra input bits appear on output 40 clocks later.
// RULE_13 - Chip select rise latches shift register as a command.
// RULE_14 - Only the last 40 bits before chip select rise count.
// RULE_15 - Serial clock at most 10MHz, asynchronous to system clock.
// RULE_16 - Single-wire datagrams open with sync nibble; reserved bits in CRC.
// RULE_17 - Write datagram: node, address, four data bytes MSB first, CRC.
// RULE_18 - Bytes framed by low start, high stop, LSB first.
// RULE_19 - Bit time measured per datagram from start to sync bit 3 edge.
// RULE_20 - Host baud between 9000 and clock over sixteen.
// RULE_21 - Low-power mode limits baud to oscillator over sixteen.
// RULE_22 - Node configuration register at 0x3 holds the node address.
// RULE_23 - Node address plus 0..7 strap increment taken after reset.
// RULE_24 - Address byte bit 7: zero read, one write.
// RULE_25 - CRC8 poly x^8+x^2+x+1, zero init, LSB first.
// RULE_26 - Act only on good CRC and own address; count writes.
module srhp_port
    import srhp_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // SPI pins
    input wire logic chip_select_n,
    input wire logic sck,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    // Single-wire pin
    input wire logic single_wire_line_in,
    output logic single_wire_line_out,
    output logic single_wire_line_oe,
    // Address straps
    input wire logic addr_select_bit2,
    input wire logic addr_select_bit1,
    input wire logic addr_select_bit0,
    // Device state
    input wire logic [4:0] stop_flags,
    input wire logic [31:0] ramp_status,
    input wire logic driver_error_event,
    // Register file port
    output logic wr_valid,
    output logic [6:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [6:0] rd_addr,
    input wire logic [31:0] rd_data,
    // Local state
    output logic [7:0] node_address,
    output logic [7:0] dgram_count
);

    function automatic srhp_byte_type crc_step(srhp_byte_type c, logic b);
        crc_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? `SRHP_CRC_POLY : 8'h00);
    endfunction

    // Synchronised pins
    wire logic [6:0] pin_q;
    wire logic cs_n_q;
    wire logic sck_q;
    wire logic sdi_q;
    wire logic line_q;
    wire logic [2:0] strap_q;

    srhp_sync #(
        .W(7),
        .RST(7'b1000110)
    ) u_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .d({single_wire_line_in, addr_select_bit2, addr_select_bit1,
            addr_select_bit0, chip_select_n, sck, sdi}),
        .q(pin_q)
    );

    assign line_q = pin_q[6];
    assign strap_q = pin_q[5:3];
    assign cs_n_q = pin_q[2];
    assign sck_q = pin_q[1];
    assign sdi_q = pin_q[0];

    // Edge detection on filtered levels
    logic cs_n_d;
    logic sck_d;
    logic line_d;
    wire logic cs_fall = cs_n_d & ~cs_n_q;
    wire logic cs_rise = ~cs_n_d & cs_n_q;
    wire logic sck_rise = ~sck_d & sck_q & ~cs_n_q;
    wire logic sck_fall = sck_d & ~sck_q & ~cs_n_q;
    wire logic line_fall = line_d & ~line_q;

    // SPI state
    logic [`SRHP_FRAME_BITS-1:0] shift;
    logic [`SRHP_FRAME_BITS-1:0] cmd;
    logic cmd_new;
    logic [31:0] reply;
    logic [7:0] status_lat;
    logic [1:0] global_status_reg;

    // Strap capture
    logic [2:0] strap_cnt;
    logic [2:0] strap_val;

    // Single-wire state
    srhp_uart_state_type ur_state;
    logic [19:0] meas;
    logic [1:0] edges;
    logic [17:0] bit_time;
    logic [17:0] timer;
    logic [25:0] wait_cnt;
    logic [6:0] idx;
    logic [63:0] frame;
    srhp_byte_type crc;
    srhp_byte_type crc24;
    srhp_byte_type crc56;
    logic uw_pend;
    logic [6:0] uw_addr;
    logic [31:0] uw_data;

    // Status byte with unused bits zero
    wire logic [7:0] status_now = {1'b0, |stop_flags, // [RULE_01] [RULE_02]
        1'b0, ramp_status[`SRHP_RAMP_POS], // [RULE_03]
        1'b0, ramp_status[`SRHP_RAMP_VEL], // [RULE_04]
        global_status_reg}; // [RULE_05] [RULE_06]

    // Command decode
    wire logic spi_write = cs_rise & shift[`SRHP_WRITE_BIT]; // [RULE_24]
    wire logic [6:0] cmd_addr = cmd[38:32];
    wire logic [31:0] cmd_data = cmd[31:0];
    wire logic [7:0] eff_addr = node_address + {5'h00, strap_val}; // [RULE_23]

    // Local registers answer reads, rest goes outside
    assign rd_addr = cmd_addr;
    wire logic [31:0] read_value =
        (cmd_addr == `SRHP_ADDR_STATUS) ? {30'h0, global_status_reg} :
        (cmd_addr == `SRHP_ADDR_NODE_CFG) ? {24'h0, node_address} :
        rd_data; // [RULE_07]

    // Write arbitration, SPI first
    wire logic any_wr = spi_write | uw_pend;
    wire logic [6:0] next_wr_addr = spi_write ? shift[38:32] : uw_addr;
    wire logic [31:0] next_wr_data = spi_write ? shift[31:0] : uw_data;
    wire logic status_wr = any_wr & (next_wr_addr == `SRHP_ADDR_STATUS);
    wire logic node_wr = any_wr & (next_wr_addr == `SRHP_ADDR_NODE_CFG);

    // Single-wire datagram fields
    wire logic [7:0] uw_node = frame[15:8];
    wire logic uw_is_write = frame[`SRHP_UW_RW_BIT]; // [RULE_24]
    wire logic [31:0] uw_word = {frame[31:24], frame[39:32], frame[47:40],
        frame[55:48]}; // [RULE_17]
    wire logic end_read = (idx == 7'd`SRHP_UW_READ_END) & ~uw_is_write;
    wire logic end_write = (idx == 7'd`SRHP_UW_WRITE_END);
    wire logic crc_ok = end_write ? (frame[63:56] == crc56) :
        (frame[31:24] == crc24); // [RULE_25]
    wire logic uw_accept = (end_read | end_write) & crc_ok &
        (uw_node == eff_addr); // [RULE_26]
    wire logic uw_timeout = wait_cnt[25:`SRHP_TIMEOUT_SHIFT] >
        {2'b00, bit_time};

    // Fixed single-wire output, transmitter disabled; sdo enabled while selected
    assign single_wire_line_out = 1'b1;
    assign single_wire_line_oe = 1'b0;
    assign sdo_oe = ~cs_n_q;

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            cs_n_d <= 1'b1;
            sck_d <= 1'b1;
            line_d <= 1'b1;
        end
        else
        begin
            cs_n_d <= cs_n_q;
            sck_d <= sck_q;
            line_d <= line_q;
        end
    end

    // SPI shift path
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            shift <= '0;
            sdo <= 1'b0;
        end
        else if (cs_fall)
        begin
            shift <= {status_lat, reply}; // [RULE_01]
            sdo <= status_lat[7];
        end
        else if (sck_rise)
        begin
            shift <= {shift[38:0], sdi_q}; // [RULE_08] [RULE_09] [RULE_14]
        end
        else if (sck_fall)
        begin
            sdo <= shift[`SRHP_FRAME_BITS-1]; // [RULE_09] [RULE_12]
        end
    end

    // Command latch and reply preparation
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            cmd <= '0;
            cmd_new <= 1'b0;
            reply <= '0;
            status_lat <= 8'h00;
        end
        else
        begin
            cmd_new <= cs_rise;
            if (cs_rise)
            begin
                cmd <= shift; // [RULE_13]
                status_lat <= status_now;
            end
            if (cmd_new)
            begin
                reply <= cmd[`SRHP_WRITE_BIT] ? cmd_data : read_value;
            end
        end
    end

    // Register writes and local registers
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_valid <= 1'b0;
            wr_addr <= 7'h00;
            wr_data <= '0;
            global_status_reg <= `SRHP_STATUS_RESET;
            node_address <= `SRHP_NODE_ADDR_RESET;
        end
        else
        begin
            wr_valid <= any_wr;
            if (any_wr)
            begin
                wr_addr <= next_wr_addr;
                wr_data <= next_wr_data;
            end
            // Event set wins over write-one clear
            global_status_reg[1] <= driver_error_event // [RULE_05]
                | (global_status_reg[1] & ~(status_wr & next_wr_data[1]));
            global_status_reg[0] <= global_status_reg[0] // [RULE_06]
                & ~(status_wr & next_wr_data[0]);
            if (node_wr)
            begin
                node_address <= next_wr_data[7:0]; // [RULE_22]
            end
        end
    end

    // Strap sampling after reset release
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            strap_cnt <= 3'd0;
            strap_val <= 3'd0;
        end
        else if (strap_cnt != `SRHP_STRAP_DELAY)
        begin
            strap_cnt <= strap_cnt + 3'd1;
            strap_val <= strap_q; // [RULE_23]
        end
    end

    // Single-wire receiver
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            ur_state <= UR_IDLE;
            meas <= '0;
            edges <= 2'd0;
            bit_time <= '0;
            timer <= '0;
            wait_cnt <= '0;
            idx <= 7'd0;
            frame <= '0;
            crc <= 8'h00;
            crc24 <= 8'h00;
            crc56 <= 8'h00;
            uw_pend <= 1'b0;
            uw_addr <= 7'h00;
            uw_data <= '0;
            dgram_count <= 8'h00;
        end
        else
        begin
            if (uw_pend & ~spi_write)
            begin
                uw_pend <= 1'b0;
            end
            case (ur_state)
                UR_IDLE:
                begin
                    meas <= '0;
                    edges <= 2'd0;
                    if (line_fall)
                    begin
                        ur_state <= UR_MEAS; // [RULE_19]
                    end
                end
                UR_MEAS:
                begin
                    meas <= meas + 20'd1;
                    if (&meas)
                    begin
                        ur_state <= UR_IDLE;
                    end
                    else if (line_fall)
                    begin
                        edges <= edges + 2'd1;
                        if (edges == 2'd1)
                        begin
                            // Start to sync bit 3 spans four bits
                            bit_time <= meas[19:2]; // [RULE_19]
                            timer <= {1'b0, meas[19:3]};
                            frame <= 64'h5; // [RULE_16]
                            crc <= crc_step(crc_step(crc_step(8'h00, 1'b1),
                                1'b0), 1'b1); // [RULE_25]
                            idx <= 7'd3;
                            ur_state <= (meas[19:2] < `SRHP_MIN_BIT_CYCLES)
                                ? UR_IDLE : UR_BIT; // [RULE_20] [RULE_21]
                        end
                    end
                end
                UR_BIT:
                begin
                    timer <= timer - 18'd1;
                    if (timer == 18'd0)
                    begin
                        frame[idx[5:0]] <= line_q; // [RULE_18]
                        if (idx < 7'd`SRHP_UW_LONG_BITS)
                        begin
                            crc <= crc_step(crc, line_q);
                        end
                        idx <= idx + 7'd1;
                        timer <= bit_time;
                        ur_state <= (idx[2:0] == 3'd7) ? UR_STOP : UR_BIT;
                    end
                    if (idx == 7'd`SRHP_UW_SHORT_BITS)
                    begin
                        crc24 <= crc;
                    end
                    if (idx == 7'd`SRHP_UW_LONG_BITS)
                    begin
                        crc56 <= crc;
                    end
                end
                UR_STOP:
                begin
                    timer <= timer - 18'd1;
                    wait_cnt <= '0;
                    if (timer == 18'd0)
                    begin
                        if (!line_q)
                        begin
                            ur_state <= UR_IDLE; // [RULE_18]
                        end
                        else if (end_read | end_write)
                        begin
                            ur_state <= UR_IDLE;
                            if (uw_accept & uw_is_write)
                            begin
                                uw_pend <= 1'b1;
                                uw_addr <= frame[22:16];
                                uw_data <= uw_word; // [RULE_17]
                                dgram_count <= dgram_count + 8'd1; // [RULE_26]
                            end
                        end
                        else
                        begin
                            ur_state <= UR_WAIT;
                        end
                    end
                end
                UR_WAIT:
                begin
                    wait_cnt <= wait_cnt + 26'd1;
                    if (uw_timeout)
                    begin
                        ur_state <= UR_IDLE;
                    end
                    else if (!line_q)
                    begin
                        timer <= {1'b0, bit_time[17:1]};
                        ur_state <= UR_START;
                    end
                end
                UR_START:
                begin
                    timer <= timer - 18'd1;
                    if (timer == 18'd0)
                    begin
                        timer <= bit_time;
                        ur_state <= line_q ? UR_IDLE : UR_BIT; // [RULE_18]
                    end
                end
                default:
                begin
                    ur_state <= UR_IDLE;
                end
            endcase
        end
    end

endmodule

// ===== src/srhp_regs.svh
`ifndef SRHP_REGS_SVH
`define SRHP_REGS_SVH

// Register indices
`define SRHP_ADDR_STATUS 7'h01
`define SRHP_ADDR_NODE_CFG 7'h03

// Reset values
`define SRHP_STATUS_RESET 2'h1
`define SRHP_NODE_ADDR_RESET 8'h00

// Status byte and ramp status bit positions
`define SRHP_ST_STOP 6
`define SRHP_ST_POS 4
`define SRHP_ST_VEL 2
`define SRHP_ST_DRVERR 1
`define SRHP_ST_RESET 0
`define SRHP_RAMP_POS 9
`define SRHP_RAMP_VEL 8

// SPI frame
`define SRHP_FRAME_BITS 40
`define SRHP_WRITE_BIT 39

// Single-wire datagram bit positions and CRC polynomial
`define SRHP_UW_NODE_LSB 8
`define SRHP_UW_ADDR_LSB 16
`define SRHP_UW_RW_BIT 23
`define SRHP_UW_SHORT_BITS 24
`define SRHP_UW_LONG_BITS 56
`define SRHP_UW_READ_END 32
`define SRHP_UW_WRITE_END 64
`define SRHP_CRC_POLY 8'h07

// Timing
`define SRHP_CLK_NS 5
`define SRHP_MIN_BIT_CYCLES 18'd16
`define SRHP_STRAP_DELAY 3'd6
`define SRHP_TIMEOUT_SHIFT 6

`endif

// ===== src/srhp_pkg.sv
package srhp_pkg;

    typedef enum logic [2:0] {
        UR_IDLE = 3'b000,
        UR_MEAS = 3'b001,
        UR_BIT = 3'b010,
        UR_STOP = 3'b011,
        UR_WAIT = 3'b100,
        UR_START = 3'b101
    } srhp_uart_state_type;

    typedef logic [7:0] srhp_byte_type;

endpackage

// ===== src/srhp_sync.sv
`timescale 1ns/10ps

module srhp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Pins in
    input wire logic [W-1:0] d,
    // Filtered levels
    output logic [W-1:0] q
);

    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    wire logic [W-1:0] next_q;

    // Level changes once second and third stage agree
    assign next_q = (ff2 & ff3) | (q & (ff2 | ff3));

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            ff1 <= RST;
            ff2 <= RST;
            ff3 <= RST;
            q <= RST;
        end
        else
        begin
            ff1 <= d;
            ff2 <= ff1;
            ff3 <= ff2;
            q <= next_q;
        end
    end

endmodule

// ===== verification/srhp_port_chk.sv
`timescale 1ns/10ps

module srhp_port_chk (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // SPI pins
    input wire logic chip_select_n,
    input wire logic sck,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe,
    // Register file port
    input wire logic wr_valid,
    input wire logic [6:0] wr_addr,
    input wire logic [31:0] wr_data,
    input wire logic [6:0] rd_addr,
    // Local state
    input wire logic [7:0] node_address,
    input wire logic [7:0] dgram_count
);
    logic sck_q;
    logic [39:0] cap;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // Frame bits as seen on the pins
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            sck_q <= 1'b1;
            cap <= '0;
        end
        else
        begin
            sck_q <= sck;
            if (!chip_select_n && sck && !sck_q)
                cap <= {cap[38:0], sdi};
        end
    end

    a_oe_needs_select: assert property (
        $rose(sdo_oe) |-> !$past(chip_select_n, 2))
        else $error("sdo enabled without select");
    a_oe_idle_off: assert property (
        chip_select_n [*8] |-> !sdo_oe)
        else $error("sdo enabled while deselected");
    a_first_bit_zero: assert property (
        $rose(sdo_oe) |-> ##1 !sdo)
        else $error("status bit 7 not zero");
    a_spi_write_cmd: assert property (
        $rose(chip_select_n) && cap[39] |-> ##[3:8] (wr_valid
            && wr_addr == cap[38:32] && wr_data == cap[31:0]))
        else $error("spi write not issued");
    a_spi_read_quiet: assert property (
        $rose(chip_select_n) && !cap[39] |-> !wr_valid [*8])
        else $error("spi read caused a write");
    a_read_addr_set: assert property (
        $rose(chip_select_n) |-> ##8 rd_addr == cap[38:32])
        else $error("read address not latched");
    a_count_step: assert property (
        $changed(dgram_count) |-> dgram_count == $past(dgram_count) + 8'h1)
        else $error("datagram count jumped");
    a_count_write: assert property (
        $changed(dgram_count) |-> (wr_valid || $past(wr_valid))
            or (##[1:2] wr_valid))
        else $error("count without write");
    a_node_written: assert property (
        $changed(node_address) |-> ##[0:2] (wr_addr == 7'h03
            && wr_data[7:0] == node_address))
        else $error("node address changed without write");
endmodule

bind srhp_port srhp_port_chk u_chk (.clk_sys(clk_sys), .nrst(nrst),
    .chip_select_n(chip_select_n), .sck(sck), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe), .wr_valid(wr_valid), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_addr(rd_addr), .node_address(node_address),
    .dgram_count(dgram_count));

// ===== verification/srhp_host.sv
`timescale 1ns/10ps

module srhp_host (
    // Clock
    input wire logic clk_sys,
    // SPI side
    output logic chip_select_n,
    output logic sck,
    output logic sdi,
    input wire logic sdo,
    // Single-wire side
    output logic single_wire_line_in
);
    localparam int HALF = 12; // 8.3 MHz

    initial
    begin
        chip_select_n = 1'b1;
        sck = 1'b1; // Idles high
        sdi = 1'b0;
        single_wire_line_in = 1'b1;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Whole frame under one select
    task automatic spi(input logic [63:0] tx, input int n,
                       output logic [63:0] rx);
        rx = '0;
        chip_select_n = 1'b0;
        step(HALF);
        for (int i = n - 1; i >= 0; i--)
        begin
            sck = 1'b0;
            sdi = tx[i]; // MSB first
            step(HALF);
            sck = 1'b1;
            rx = {rx[62:0], sdo}; // Sampled on rise
            step(HALF);
        end
        chip_select_n = 1'b1;
        sdi = ~sdi;
        step(24);
    endtask

    // Start low, stop high, LSB first
    task automatic uart(input logic [7:0] b [8], input int bt);
        for (int k = 0; k < 8; k++)
            for (int i = -1; i < 9; i++)
            begin
                single_wire_line_in = i < 0 ? 1'b0 : i > 7 ? 1'b1 : b[k][i];
                step(bt);
            end
        step(12 * bt);
    endtask
endmodule

// ===== verification/serial_host_register_port_bench.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) \
    begin \
        comparisons++; \
        if ((g) !== (e)) \
        begin \
            failures++; \
            $display("ERROR %s expected %h seen %h", nm, e, g); \
        end \
    end

module serial_host_register_port_bench;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic chip_select_n, sck, sdi, sdo, sdo_oe, line_in, line_out, line_oe;
    logic [2:0] strap;
    logic [4:0] stop_flags = '0;
    logic [31:0] ramp_status = '0;
    logic driver_error_event = 1'b0;
    logic wr_valid;
    logic [6:0] wr_addr, rd_addr;
    logic [31:0] wr_data;
    logic [31:0] rd_data = '0;
    logic [7:0] node_address, dgram_count;
    logic [31:0] seed = 32'h9b262144;
    int failures = 0;
    int comparisons = 0;
    logic [1:0] exp_gs = 2'b01;
    logic [7:0] exp_node = 8'h00;
    logic [7:0] exp_cnt = 8'h00;
    logic [7:0] ns = 8'h00;
    logic [31:0] exp_d = '0;
    wire sdo_pin = sdo_oe ? sdo : 1'bz;

    initial
    begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    srhp_port u_dut (.clk_sys(clk_sys), .nrst(nrst),
        .chip_select_n(chip_select_n), .sck(sck), .sdi(sdi), .sdo(sdo),
        .sdo_oe(sdo_oe), .single_wire_line_in(line_in),
        .single_wire_line_out(line_out), .single_wire_line_oe(line_oe),
        .addr_select_bit2(strap[2]), .addr_select_bit1(strap[1]),
        .addr_select_bit0(strap[0]), .stop_flags(stop_flags),
        .ramp_status(ramp_status), .driver_error_event(driver_error_event),
        .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_addr(rd_addr), .rd_data(rd_data), .node_address(node_address),
        .dgram_count(dgram_count));

    srhp_host u_host (.clk_sys(clk_sys), .chip_select_n(chip_select_n),
        .sck(sck), .sdi(sdi), .sdo(sdo_pin), .single_wire_line_in(line_in));

    function automatic logic [31:0] predict(input logic [39:0] c);
        if (c[39])
            return c[31:0];
        if (c[38:32] == 7'h01)
            return {30'h0, exp_gs};
        if (c[38:32] == 7'h03)
            return {24'h0, exp_node};
        return rd_data;
    endfunction

    function automatic logic [7:0] crc(input logic [7:0] b [8]);
        crc = 8'h00;
        for (int k = 0; k < 7; k++)
            for (int i = 0; i < 8; i++)
                crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ b[k][i]) ? 8'h07 : 8'h00);
    endfunction

    task automatic close_out;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic xfer(input logic [39:0] c, input int ex, input bit chk);
        logic [63:0] tx;
        logic [63:0] rx;
        logic [23:0] m;
        tx = {$random(seed), $random(seed)};
        tx[39:0] = c;
        m = 24'((64'h1 << ex) - 64'h1);
        u_host.spi(tx, 40 + ex, rx);
        `CHK("pass", tx[63:40] & m, rx[23:0] & m)
        rx = rx >> ex;
        if (chk)
        begin
            `CHK("data", exp_d, rx[31:0])
            `CHK("st hi", ns[7:3], rx[39:35])
            `CHK("st lo", ns[2:0], rx[34:32])
        end
        if (c[39] && c[38:32] == 7'h01)
            exp_gs = exp_gs & ~c[1:0];
        if (c[39] && c[38:32] == 7'h03)
            exp_node = c[7:0];
        exp_d = predict(c);
        ns = {1'b0, |stop_flags, 1'b0, ramp_status[9], 1'b0, ramp_status[8],
              exp_gs};
    endtask

    task automatic dgram(input logic [7:0] node, input logic [6:0] ra,
                         input logic [31:0] d, input bit good);
        logic [7:0] b [8];
        logic acc;
        acc = good && node == exp_node + 8'(strap);
        b[0] = {4'($random(seed)), 4'h5};
        b[1] = node;
        b[2] = {1'b1, ra};
        for (int k = 0; k < 4; k++)
            b[3 + k] = d[31 - 8 * k -: 8];
        b[7] = crc(b) ^ {7'h0, !good};
        u_host.uart(b, 20 + {$random(seed)} % 21);
        exp_cnt = exp_cnt + 8'(acc);
        `CHK("count", exp_cnt, dgram_count)
        if (acc)
            `CHK("uart wr", {ra, d}, {wr_addr, wr_data})
        if (acc && ra == 7'h03)
            exp_node = d[7:0];
    endtask

    initial
    begin
        strap = 3'($random(seed));
        rd_data = $random(seed);
        repeat (16) @(posedge clk_sys);
        #1 nrst = 1'b1;
        repeat (8) @(posedge clk_sys);
        #1;
        `CHK("node reset", 8'h00, node_address)
        `CHK("count reset", 8'h00, dgram_count)
        `CHK("line idle", 2'b01, {line_oe, line_out})
        xfer(40'h03_0000_0000, 0, 0);
        xfer(40'h01_0000_0000, 0, 1);
        xfer(40'h22_0000_0000, 8, 1);
        xfer(40'h01_0000_0000, 24, 1);
        for (int i = 0; i < 12; i++)
        begin
            stop_flags = i < 5 ? 5'(1 << i) : i == 5 ? 5'h0 : 5'($random(seed));
            ramp_status = $random(seed);
            xfer({1'b0, 7'($random(seed)), 32'h0}, {$random(seed)} % 25, 1);
        end
        driver_error_event = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1 driver_error_event = 1'b0;
        exp_gs[1] = 1'b1;
        xfer(40'h01_0000_0000, 0, 1);
        xfer(40'h81_0000_0003, 0, 1);
        xfer(40'h01_0000_0000, 0, 0);
        xfer(40'h01_0000_0000, 0, 1);
        dgram(exp_node + 8'(strap), 7'h03, {24'h0, 8'($random(seed))}, 1);
        dgram(exp_node + 8'(strap), 7'h10, $random(seed), 0);
        dgram(exp_node + 8'(strap) + 8'h1, 7'h10, $random(seed), 1);
        dgram(exp_node + 8'(strap), 7'h10, $random(seed), 1);
        `CHK("node", exp_node, node_address)
        xfer(40'h03_0000_0000, 0, 1);
        xfer({8'h83, 24'h0, 8'($random(seed))}, 16, 1);
        xfer(40'h03_0000_0000, 0, 1);
        xfer(40'h00_0000_0000, 0, 1);
        `CHK("node", exp_node, node_address)
        close_out;
    end

    initial
    begin
        #450000;
        failures++;
        close_out;
    end
endmodule
